// *** rtl/bal_pkg.sv ***
/*
  Shared constants and types of the byte arithmetic and logic unit:
  register offsets, flag bit positions, reset values and command codes.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package bal_pkg;

  localparam int BYTE_W = 8;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_DEST = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DEST_HI = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_SRC = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_CMD = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Flag bit positions in the flag register
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;

  // Status register bit positions
  localparam int STS_BUSY = 0;
  localparam int STS_CMD_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed byte constants
  localparam logic [BYTE_W-1:0] DEST_RST = 8'h00;
  localparam logic [BYTE_W-1:0] SRC_RST = 8'h00;
  localparam logic [BYTE_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hff;
  localparam logic [BUS_W-1:0] BUS_ZERO = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes written to the command register
  typedef enum logic [4:0] {
    op_add = 5'h00,
    op_add_carry = 5'h01,
    op_word_plus_imm = 5'h02,
    op_sub_regs = 5'h03,
    op_diff_reg_imm = 5'h04,
    op_diff_borrow_regs = 5'h05,
    op_diff_borrow_imm = 5'h06,
    op_word_minus_imm = 5'h07,
    op_conj_regs = 5'h08,
    op_bitwise_conj_imm = 5'h09,
    op_disj_regs = 5'h0a,
    op_bitwise_disj_imm = 5'h0b,
    op_bitwise_xor_regs = 5'h0c,
    op_ones_invert = 5'h0d,
    op_twos_invert = 5'h0e,
    op_mask_set_bits = 5'h0f,
    op_mask_clear_bits = 5'h10
  } bal_op_t;

  localparam bal_op_t OP_RST = op_add;

  typedef enum logic [1:0] {
    st_idle,
    st_exec,
    st_word_high
  } bal_state_t;

endpackage

// *** rtl/bal_byte_arith.sv ***
/*
  Eight-bit adder and subtractor with carry, half-carry and overflow.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/10ps
module bal_byte_arith
(
  input wire logic [bal_pkg::BYTE_W-1:0] a,
  input wire logic [bal_pkg::BYTE_W-1:0] b,
  input wire logic is_sub,
  input wire logic carry_in,
  output logic [bal_pkg::BYTE_W-1:0] res,
  output logic carry,
  output logic half,
  output logic ovf
);
  import bal_pkg::*;

  // Half-carry is taken out of the low nibble
  localparam int NIB_W = BYTE_W / 2;

  logic [BYTE_W-1:0] b_eff;
  logic cin_eff;
  logic [BYTE_W:0] sum;
  logic [NIB_W:0] low_sum;

  // Subtraction as a plus inverted b plus inverted borrow
  assign b_eff = is_sub ? ~b : b;
  assign cin_eff = is_sub ? ~carry_in : carry_in;
  assign sum = {1'b0, a} + {1'b0, b_eff} + {{BYTE_W{1'b0}}, cin_eff};
  assign low_sum = {1'b0, a[NIB_W-1:0]} + {1'b0, b_eff[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin_eff};
  assign res = sum[BYTE_W-1:0];
  // Borrow is the inverse of the carry out
  assign carry = sum[BYTE_W] ^ is_sub;
  assign half = low_sum[NIB_W] ^ is_sub;
  assign ovf = (a[BYTE_W-1] == b_eff[BYTE_W-1]) && (res[BYTE_W-1] != a[BYTE_W-1]);

endmodule

// *** rtl/bal_alu.sv ***
/*
  Byte arithmetic and logic unit with an Avalon-MM register slave.
  Software loads the destination (and its high byte for word commands) and
  the source or immediate, then writes a command; the result is written back
  into the destination registers and the flags register is updated.
  Assumes a single clock and a master that holds its request while
  waitrequest is high.
*/
// Summary of operation
// - Add source to destination, optionally plus carry; update Z C N V H; one clock.
// - Add immediate to sixteen-bit pair; update Z C N V S; two clocks.
// - Subtract register or immediate from destination; update Z C N V H; one clock.
// - Subtract source and carry from destination; update Z C N V H; one clock.
// - Subtract immediate and carry from destination; update Z C N V H; one clock.
// - Subtract immediate from sixteen-bit pair, both bytes back; Z C N V S; two clocks.
// - AND destination with register or immediate; update only Z N V; one clock.
// - OR with register or immediate, or XOR registers; update Z N V; one clock.
// - Set destination bits selected by mask via OR; update Z N V; one clock.
// - Clear destination bits by AND with mask inverted; update Z N V; one clock.
`timescale 1ns/10ps
module bal_alu
#(
  parameter int DATA_W = 32,
  parameter int ADDR_BITS = 5
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_BITS-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W/8-1:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic busy
);
  import bal_pkg::*;

  if (DATA_W != BUS_W) begin : g_bad_data_w
    $error("bal_alu: DATA_W must be 32");
  end
  if (ADDR_BITS != ADDR_W) begin : g_bad_addr_w
    $error("bal_alu: ADDR_BITS must be 5");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decoding helpers
  function automatic logic is_word_op(input bal_op_t op);
    is_word_op = (op == op_word_plus_imm) || (op == op_word_minus_imm);
  endfunction

  function automatic logic is_logic_op(input bal_op_t op);
    case (op)
      op_conj_regs, op_bitwise_conj_imm, op_disj_regs, op_bitwise_disj_imm,
      op_bitwise_xor_regs, op_mask_set_bits, op_mask_clear_bits: begin
        is_logic_op = 1'b1;
      end
      default: begin
        is_logic_op = 1'b0;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  bal_state_t state;
  bal_op_t cmd;
  logic [BYTE_W-1:0] dest;
  logic [BYTE_W-1:0] dest_hi;
  logic [BYTE_W-1:0] src;
  logic [BYTE_W-1:0] flags;
  logic [BYTE_W-1:0] low_res;
  logic low_carry;
  logic low_zero;
  logic ack;

  logic bus_req;
  logic bus_done;
  logic wr_lane0;
  logic cmd_start;

  logic [BYTE_W-1:0] ar_a;
  logic [BYTE_W-1:0] ar_b;
  logic ar_sub;
  logic ar_cin;
  logic [BYTE_W-1:0] ar_res;
  logic ar_carry;
  logic ar_half;
  logic ar_ovf;

  logic [BYTE_W-1:0] next_res;
  logic [BYTE_W-1:0] next_flags;
  logic res_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave handshake
  // One wait cycle per access; further stall while a command executes
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack;
  assign bus_done = bus_req && ack;
  assign wr_lane0 = bus_done && avs_write && avs_byteenable[0];
  assign cmd_start = wr_lane0 && (avs_address == OFS_CMD);
  assign busy = (state != st_idle);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req && !ack && (state == st_idle);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= BUS_ZERO;
    end else if (bus_req && !ack && (state == st_idle)) begin
      avs_readdata <= BUS_ZERO;
      case (avs_address)
        OFS_DEST: begin
          avs_readdata[BYTE_W-1:0] <= dest;
        end
        OFS_DEST_HI: begin
          avs_readdata[BYTE_W-1:0] <= dest_hi;
        end
        OFS_SRC: begin
          avs_readdata[BYTE_W-1:0] <= src;
        end
        OFS_FLAGS: begin
          avs_readdata[BYTE_W-1:0] <= flags;
        end
        OFS_CMD: begin
          avs_readdata[$bits(bal_op_t)-1:0] <= cmd;
        end
        OFS_STATUS: begin
          avs_readdata[STS_BUSY] <= busy;
          avs_readdata[STS_CMD_LSB +: $bits(bal_op_t)] <= cmd;
        end
        default: begin
          avs_readdata <= BUS_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one clock for byte commands, two for word commands
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (cmd_start) begin
            state <= st_exec;
          end
        end
        st_exec: begin
          if (is_word_op(cmd)) begin
            state <= st_word_high;
          end else begin
            state <= st_idle;
          end
        end
        st_word_high: begin
          state <= st_idle;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= OP_RST;
    end else if (cmd_start) begin
      cmd <= bal_op_t'(avs_writedata[$bits(bal_op_t)-1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic operand selection
  always_comb begin
    ar_a = dest;
    ar_b = src;
    ar_sub = 1'b0;
    ar_cin = 1'b0;
    case (cmd)
      op_add_carry: begin
        ar_cin = flags[FLG_C];
      end
      op_sub_regs, op_diff_reg_imm: begin
        ar_sub = 1'b1;
      end
      op_diff_borrow_regs, op_diff_borrow_imm: begin
        ar_sub = 1'b1;
        ar_cin = flags[FLG_C];
      end
      op_twos_invert: begin
        ar_a = BYTE_ZERO;
        ar_b = dest;
        ar_sub = 1'b1;
      end
      op_word_plus_imm, op_word_minus_imm: begin
        ar_sub = (cmd == op_word_minus_imm);
        if (state == st_word_high) begin
          ar_a = dest_hi;
          ar_b = BYTE_ZERO;
          ar_cin = low_carry;
        end
      end
      default: begin
        ar_sub = 1'b0;
      end
    endcase
  end

  bal_byte_arith u_arith (
    .a(ar_a),
    .b(ar_b),
    .is_sub(ar_sub),
    .carry_in(ar_cin),
    .res(ar_res),
    .carry(ar_carry),
    .half(ar_half),
    .ovf(ar_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result and flag computation
  always_comb begin
    next_res = ar_res;
    case (cmd)
      op_conj_regs, op_bitwise_conj_imm: begin
        next_res = dest & src;
      end
      op_disj_regs, op_bitwise_disj_imm: begin
        next_res = dest | src;
      end
      op_bitwise_xor_regs: begin
        next_res = dest ^ src;
      end
      op_mask_set_bits: begin
        next_res = dest | src;
      end
      op_mask_clear_bits: begin
        next_res = dest & (BYTE_ONES - src);
      end
      op_ones_invert: begin
        next_res = BYTE_ONES - dest;
      end
      default: begin
        next_res = ar_res;
      end
    endcase
  end

  assign res_zero = (next_res == BYTE_ZERO);

  always_comb begin
    next_flags = flags;
    next_flags[FLG_Z] = res_zero;
    next_flags[FLG_N] = next_res[BYTE_W-1];
    if (is_logic_op(cmd)) begin
      next_flags[FLG_V] = 1'b0;
    end else if (cmd == op_ones_invert) begin
      next_flags[FLG_V] = 1'b0;
      next_flags[FLG_C] = 1'b1;
    end else if (is_word_op(cmd)) begin
      // High byte step carries the sixteen-bit flags
      next_flags[FLG_Z] = res_zero && low_zero;
      next_flags[FLG_V] = ar_ovf;
      next_flags[FLG_C] = ar_carry;
      next_flags[FLG_S] = next_res[BYTE_W-1] ^ ar_ovf;
    end else begin
      next_flags[FLG_V] = ar_ovf;
      next_flags[FLG_C] = ar_carry;
      next_flags[FLG_H] = ar_half;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low byte of a word command kept for the second clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_res <= BYTE_ZERO;
      low_carry <= 1'b0;
      low_zero <= 1'b0;
    end else if (state == st_exec) begin
      low_res <= ar_res;
      low_carry <= ar_carry;
      low_zero <= (ar_res == BYTE_ZERO);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Destination write-back and software writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dest <= DEST_RST;
    end else if ((state == st_exec) && !is_word_op(cmd)) begin
      dest <= next_res;
    end else if (state == st_word_high) begin
      dest <= low_res;
    end else if (wr_lane0 && (avs_address == OFS_DEST)) begin
      dest <= avs_writedata[BYTE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dest_hi <= DEST_RST;
    end else if (state == st_word_high) begin
      dest_hi <= next_res;
    end else if (wr_lane0 && (avs_address == OFS_DEST_HI)) begin
      dest_hi <= avs_writedata[BYTE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      src <= SRC_RST;
    end else if (wr_lane0 && (avs_address == OFS_SRC)) begin
      src <= avs_writedata[BYTE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= FLAGS_RST;
    end else if (((state == st_exec) && !is_word_op(cmd)) || (state == st_word_high)) begin
      flags <= next_flags;
    end else if (wr_lane0 && (avs_address == OFS_FLAGS)) begin
      flags <= avs_writedata[BYTE_W-1:0];
    end
  end

endmodule

// *** test/bal_alu_chk.sv ***
/*
  Port checker of the byte ALU: command timing and bus stalls.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module bal_alu_chk
  import bal_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_BITS = 5
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_BITS-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W/8-1:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic busy
);
  logic go;
  logic [4:0] op;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  assign go = avs_write && !avs_waitrequest && avs_address == OFS_CMD && avs_byteenable[0];
  assign op = avs_writedata[4:0];
  ////////////////////////////////////////////////////////////////////////////
  property p_add; go && op inside {5'h00, 5'h01} |=> busy ##1 !busy; endproperty
  a_add: assert property (p_add) else $error("add length wrong");
  property p_wadd; go && op == 5'h02 |=> busy [*2] ##1 !busy; endproperty
  a_wadd: assert property (p_wadd) else $error("word add length wrong");
  property p_sub; go && op inside {5'h03, 5'h04} |=> busy ##1 !busy; endproperty
  a_sub: assert property (p_sub) else $error("sub length wrong");
  property p_sbc; go && op inside {5'h05, 5'h06} |=> busy ##1 !busy; endproperty
  a_sbc: assert property (p_sbc) else $error("borrow length wrong");
  property p_wsub; go && op == 5'h07 |=> busy [*2] ##1 !busy; endproperty
  a_wsub: assert property (p_wsub) else $error("word sub length wrong");
  property p_logic; go && op inside {[5'h08:5'h0c], 5'h0f, 5'h10} |=> busy ##1 !busy; endproperty
  a_logic: assert property (p_logic) else $error("logic length wrong");
  property p_inv; go && op inside {5'h0d, 5'h0e} |=> busy ##1 !busy; endproperty
  a_inv: assert property (p_inv) else $error("invert length wrong");
  property p_stall; busy && (avs_read || avs_write) |-> avs_waitrequest; endproperty
  a_stall: assert property (p_stall) else $error("access not stalled");
  c_word: cover property (go && op == 5'h07);
  c_byte: cover property (go && op == 5'h0e);
  c_stall: cover property (busy && avs_write);
endmodule

// *** test/bal_bus_host.sv ***
/*
  Register bus master standing in for the decoder side.
  Assumes the slave answers by dropping waitrequest.
*/
`timescale 1ns/10ps
module bal_bus_host (
  input wire logic sys_clk,
  output logic [4:0] address = 5'h00,
  output logic read = 1'b0,
  output logic write = 1'b0,
  output logic [31:0] writedata = 32'h0,
  output logic [3:0] byteenable = 4'h0,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    @(posedge sys_clk);
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Released lines show garbage, not the last value
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule

// *** test/test_byte_alu_arith_logic.sv ***
/*
  Self-checking bench of the byte ALU against a reference model.
  Assumes the bus host model and checker are compiled first.
*/
`timescale 1ns/10ps
module test_byte_alu_arith_logic;
  import bal_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] address;
  logic read, write, waitrequest, busy;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [23:0] e;
  int errors = 0, checks = 0, seed = 32'h301c, n, d, h, s, f, code;
  initial forever #2 sys_clk = ~sys_clk;
  bal_bus_host bal_bus_host_i (.sys_clk(sys_clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
  bal_alu bal_alu_i (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(address), .avs_read(read),
    .avs_write(write), .avs_writedata(writedata), .avs_byteenable(byteenable), .avs_readdata(readdata),
    .avs_waitrequest(waitrequest), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  // Reference result: {dest_hi, dest, flags}
  function automatic logic [23:0] model(int op, int d, int h, int s, int f);
    int r, c, w;
    logic [7:0] g;
    g = 8'(f);
    c = f & 1;
    case (op)
      2, 7: begin
        w = h * 256 + d;
        r = op == 2 ? w + s : w - s;
        g[0] = op == 2 ? r > 65535 : w < s;
        r &= 65535;
        g[3] = op == 2 ? (!w[15] && r[15]) : (w[15] && !r[15]);
        g[2] = r[15];
        g[4] = g[2] ^ g[3];
        g[1] = r == 0;
        return {r[15:0], g};
      end
      3, 4, 5, 6: begin
        c = op > 4 ? c : 0;
        r = d - s - c;
        g[0] = d < s + c;
        g[5] = (d & 15) < (s & 15) + c;
        g[3] = d[7] != s[7] && r[7] != d[7];
      end
      8, 9, 10, 11, 12, 15, 16: begin
        r = op < 10 ? d & s : op == 12 ? d ^ s : op == 16 ? d & (255 - s) : d | s;
        g[3] = 1'b0;
      end
      13: begin
        r = 255 - d;
        g[0] = 1'b1;
        g[3] = 1'b0;
      end
      14: begin
        r = (0 - d) & 255;
        g[0] = r != 0;
        g[5] = (d & 15) != 0;
        g[3] = r == 128;
      end
      default: begin
        c = op == 1 ? c : 0;
        r = d + s + c;
        g[0] = r > 255;
        g[5] = (d & 15) + (s & 15) + c > 15;
        g[3] = d[7] == s[7] && r[7] != d[7];
      end
    endcase
    r &= 255;
    g[2] = r[7];
    g[1] = r == 0;
    return {h[7:0], r[7:0], g};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input int v, input logic [3:0] be);
    logic [31:0] x;
    bal_bus_host_i.xfer(1'b0, a, 32'(v), be, x);
  endtask
  task automatic rd(input logic [4:0] a);
    bal_bus_host_i.xfer(1'b1, a, 32'h0, 4'hf, q);
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 7; n++) begin
      rd(5'(n * 4));
      chk("reset value", q, 32'h0);
    end
    wr(5'h18, 32'h5a, 4'hf);
    rd(5'h18);
    chk("unmapped", q, 32'h0);
    wr(OFS_SRC, 32'h3c, 4'hf);
    wr(OFS_SRC, 32'hc3, 4'h0);
    rd(OFS_SRC);
    chk("lane off", q, 32'h3c);
    for (n = 0; n < 54; n++) begin
      code = n / 3 == 17 ? 31 : n / 3;
      d = $random(seed) & 255;
      h = $random(seed) & 255;
      s = n % 3 == 0 ? d : $random(seed) & 255;
      f = $random(seed) & 255;
      wr(OFS_DEST, d, 4'hf);
      wr(OFS_DEST_HI, h, 4'hf);
      wr(OFS_SRC, s, 4'hf);
      wr(OFS_FLAGS, f, 4'hf);
      wr(OFS_CMD, code, 4'hf);
      wr(OFS_STATUS, 32'hff, 4'hf);
      e = model(code, d, h, s, f);
      rd(OFS_DEST);
      chk("dest", q, 32'(e[15:8]));
      rd(OFS_DEST_HI);
      chk("dest_hi", q, 32'(e[23:16]));
      rd(OFS_FLAGS);
      chk("flags", q, 32'(e[7:0]));
      rd(OFS_STATUS);
      chk("status", q, 32'(code) << 8);
    end
    conclude();
  end
endmodule
bind bal_alu bal_alu_chk #(.DATA_W(DATA_W), .ADDR_BITS(ADDR_BITS)) bal_alu_chk_i (.sys_clk(sys_clk),
  .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .busy(busy));
